/* rdpc_pkg.sv */
// ****************************************************************
// Reset and debug pin configuration constants
// ****************************************************************
// Function
// - Power-on reset leaves shared pin as port
// - Setting reset select makes pin reset input
// - Reset select sticks until next power-on
// - Low reset pin resets whole controller
// - Reset select forces pin pullup on
// - Interrupt select pullup follows pull-disable bit
// - Keypad edge polarity turns pullup into pulldown
// - Per-pin pullups only act on inputs
// - Debug pin is mode input during reset
// - Debug pin serves debug link after reset
// - Every reset sets debug select bit
// - Debug select forces debug pin pullup
// - High strap at release gives normal mode
// - Low strap at release gives background mode
// - Force-reset write with low strap enters background
// - Reset pin always restarts in user mode
// - Each debug bit lasts sixteen clocks
// - Driven speedup pulse ends each low bit
// - All registers run on the bus clock
package rdpc_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_SYS_OPT = 8'h00;
    localparam logic [7:0] OFF_PULL_EN = 8'h04;
    localparam logic [7:0] OFF_PIN_DIR = 8'h08;
    localparam logic [7:0] OFF_KEYPAD = 8'h0C;
    localparam logic [7:0] OFF_DBG_FORCE = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_PORT_OUT = 8'h18;
    localparam logic [7:0] OFF_PIN_IN = 8'h1C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned BIT_RST_SEL = 0;
    localparam int unsigned BIT_IRQ_SEL = 1;
    localparam int unsigned BIT_IRQ_PDIS = 2;
    localparam int unsigned BIT_DBG_SEL = 3;
    localparam int unsigned BIT_CMP_SEL = 4;
    localparam int unsigned BIT_FORCE = 0;
    localparam int unsigned PIN_RST = 5;
    localparam int unsigned PIN_DBG = 4;
    localparam int unsigned NUM_PINS = 6;
    localparam int unsigned NUM_KEYS = 4;

    // ************************************************************
    // Debug bit timing in clock cycles
    // ************************************************************
    localparam logic [4:0] BIT_CYCLES = 5'h10;
    localparam logic [4:0] LOW_ONE = 5'h04;
    localparam logic [4:0] LOW_ZERO = 5'h0D;
    localparam logic [4:0] SPEEDUP_CYCLES = 5'h01;

    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01
    } rdpc_state_t;

    typedef enum logic [1:0] {
        CAUSE_POR = 2'b00,
        CAUSE_PIN = 2'b01,
        CAUSE_FORCE = 2'b10
    } rdpc_cause_t;

    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
        logic [5:0] pu;
        logic [5:0] pd;
    } rdpc_pads_t;

endpackage

/* rdpc_top.sv */
module rdpc_top #(
    parameter int unsigned RST_HOLD = 8
) (
    // Clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Pads
    input wire logic [5:0] pad_in_i,
    output rdpc_pkg::rdpc_pads_t pads_o,
    // Peripheral sources
    input wire logic comparator_output_i,
    // Background debug controller side
    input wire logic bdc_tx_start_i,
    input wire logic bdc_tx_bit_i,
    output logic bdc_tx_done_o,
    output logic bdc_rx_o,
    // System reset and mode
    output logic chip_reset_o,
    output logic background_halt_mode_o
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic wb_hit(input logic [7:0] adr, input logic [7:0] off);
        wb_hit = ({adr[7:2], 2'b00} == off);
    endfunction

    function automatic logic [4:0] low_time(input logic bit_val);
        low_time = bit_val ? rdpc_pkg::LOW_ONE : rdpc_pkg::LOW_ZERO;
    endfunction

    localparam int unsigned HW = $clog2(RST_HOLD + 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(RST_HOLD - 1);

    // ************************************************************
    // State
    // ************************************************************
    rdpc_pkg::rdpc_state_t st_q;
    rdpc_pkg::rdpc_cause_t cause_q;
    logic [HW-1:0] hold_q;
    logic bg_mode_q;
    logic rst_sel_q;
    logic irq_sel_q;
    logic irq_pdis_q;
    logic dbg_sel_q;
    logic cmp_sel_q;
    logic [5:0] pull_en_q;
    logic [5:0] dir_q;
    logic [5:0] port_out_q;
    logic [3:0] key_sel_q;
    logic [3:0] key_pol_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [4:0] tx_cnt_q;
    logic tx_bit_q;
    logic tx_done_q;
    logic in_hold;
    logic wr_en;
    logic force_req;
    logic pin_req;
    logic tx_go;
    logic [4:0] tx_low;
    logic [31:0] rd_val;
    logic [5:0] base_pu;

    assign in_hold = (st_q == rdpc_pkg::ST_HOLD);
    assign wr_en = cyc_i && stb_i && we_i && ack_q && sel_i[0] && !in_hold;
    assign force_req = wr_en && wb_hit(adr_i, rdpc_pkg::OFF_DBG_FORCE)
        && dat_i[rdpc_pkg::BIT_FORCE];
    assign pin_req = rst_sel_q && !pad_in_i[rdpc_pkg::PIN_RST];
    assign chip_reset_o = in_hold;
    assign background_halt_mode_o = bg_mode_q;

    // ************************************************************
    // Reset sequencer
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= rdpc_pkg::ST_HOLD;
            cause_q <= rdpc_pkg::CAUSE_POR;
            hold_q <= '0;
        end else if (force_req) begin
            st_q <= rdpc_pkg::ST_HOLD;
            cause_q <= rdpc_pkg::CAUSE_FORCE;
            hold_q <= '0;
        end else if (pin_req) begin
            st_q <= rdpc_pkg::ST_HOLD;
            cause_q <= rdpc_pkg::CAUSE_PIN;
            hold_q <= '0;
        end else begin
            case (st_q)
                rdpc_pkg::ST_HOLD: begin
                    if (hold_q == HOLD_LAST) begin
                        st_q <= rdpc_pkg::ST_RUN;
                    end else begin
                        hold_q <= hold_q + HW'(1);
                    end
                end
                rdpc_pkg::ST_RUN: begin
                    st_q <= rdpc_pkg::ST_RUN;
                end
                default: begin
                    st_q <= rdpc_pkg::ST_HOLD;
                end
            endcase
        end
    end

    // ************************************************************
    // Mode strap latch
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bg_mode_q <= 1'b0;
        end else if (in_hold && hold_q == HOLD_LAST && !force_req && !pin_req) begin
            if (cause_q == rdpc_pkg::CAUSE_PIN) begin
                bg_mode_q <= 1'b0;
            end else begin
                bg_mode_q <= !pad_in_i[rdpc_pkg::PIN_DBG];
            end
        end
    end

    // ************************************************************
    // Option registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_sel_q <= 1'b0;
        end else if (wr_en && wb_hit(adr_i, rdpc_pkg::OFF_SYS_OPT)
                     && dat_i[rdpc_pkg::BIT_RST_SEL]) begin
            rst_sel_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || in_hold) begin
            irq_sel_q <= 1'b0;
            irq_pdis_q <= 1'b0;
            dbg_sel_q <= 1'b1;
            cmp_sel_q <= 1'b0;
            pull_en_q <= '0;
            dir_q <= '0;
            port_out_q <= '0;
            key_sel_q <= '0;
            key_pol_q <= '0;
        end else if (wr_en) begin
            if (wb_hit(adr_i, rdpc_pkg::OFF_SYS_OPT)) begin
                irq_sel_q <= dat_i[rdpc_pkg::BIT_IRQ_SEL];
                irq_pdis_q <= dat_i[rdpc_pkg::BIT_IRQ_PDIS];
                dbg_sel_q <= dat_i[rdpc_pkg::BIT_DBG_SEL];
                cmp_sel_q <= dat_i[rdpc_pkg::BIT_CMP_SEL];
            end
            if (wb_hit(adr_i, rdpc_pkg::OFF_PULL_EN)) begin
                pull_en_q <= dat_i[5:0];
            end
            if (wb_hit(adr_i, rdpc_pkg::OFF_PIN_DIR)) begin
                dir_q <= dat_i[5:0];
            end
            if (wb_hit(adr_i, rdpc_pkg::OFF_PORT_OUT)) begin
                port_out_q <= dat_i[5:0];
            end
            if (wb_hit(adr_i, rdpc_pkg::OFF_KEYPAD)) begin
                key_sel_q <= dat_i[3:0];
                key_pol_q <= dat_i[7:4];
            end
        end
    end

    // ************************************************************
    // Wishbone answer
    // ************************************************************
    always_comb begin
        rd_val = '0;
        if (wb_hit(adr_i, rdpc_pkg::OFF_SYS_OPT)) begin
            rd_val[rdpc_pkg::BIT_RST_SEL] = rst_sel_q;
            rd_val[rdpc_pkg::BIT_IRQ_SEL] = irq_sel_q;
            rd_val[rdpc_pkg::BIT_IRQ_PDIS] = irq_pdis_q;
            rd_val[rdpc_pkg::BIT_DBG_SEL] = dbg_sel_q;
            rd_val[rdpc_pkg::BIT_CMP_SEL] = cmp_sel_q;
        end else if (wb_hit(adr_i, rdpc_pkg::OFF_PULL_EN)) begin
            rd_val[5:0] = pull_en_q;
        end else if (wb_hit(adr_i, rdpc_pkg::OFF_PIN_DIR)) begin
            rd_val[5:0] = dir_q;
        end else if (wb_hit(adr_i, rdpc_pkg::OFF_KEYPAD)) begin
            rd_val[7:0] = {key_pol_q, key_sel_q};
        end else if (wb_hit(adr_i, rdpc_pkg::OFF_STATUS)) begin
            rd_val[2:0] = {cause_q, bg_mode_q};
        end else if (wb_hit(adr_i, rdpc_pkg::OFF_PORT_OUT)) begin
            rd_val[5:0] = port_out_q;
        end else if (wb_hit(adr_i, rdpc_pkg::OFF_PIN_IN)) begin
            rd_val[5:0] = pad_in_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= cyc_i && stb_i && !ack_q;
            if (cyc_i && stb_i && !ack_q) begin
                dat_q <= rd_val;
            end
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // ************************************************************
    // Debug bit transmitter
    // ************************************************************
    assign tx_go = bdc_tx_start_i && dbg_sel_q && !in_hold && (tx_cnt_q == '0);
    assign tx_low = low_time(tx_bit_q);
    assign bdc_rx_o = pad_in_i[rdpc_pkg::PIN_DBG];
    assign bdc_tx_done_o = tx_done_q;

    always_ff @(posedge clk_i) begin
        if (rst_i || in_hold) begin
            tx_cnt_q <= '0;
            tx_bit_q <= 1'b0;
            tx_done_q <= 1'b0;
        end else begin
            tx_done_q <= (tx_cnt_q == rdpc_pkg::BIT_CYCLES);
            if (tx_go) begin
                tx_cnt_q <= 5'h01;
                tx_bit_q <= bdc_tx_bit_i;
            end else if (tx_cnt_q == rdpc_pkg::BIT_CYCLES) begin
                tx_cnt_q <= '0;
            end else if (tx_cnt_q != '0) begin
                tx_cnt_q <= tx_cnt_q + 5'h01;
            end
        end
    end

    // ************************************************************
    // Pad drive and pull control
    // ************************************************************
    always_comb begin
        pads_o.out = port_out_q;
        pads_o.oe = dir_q;
        pads_o.oe[rdpc_pkg::PIN_RST] = 1'b0;
        pads_o.out[rdpc_pkg::PIN_RST] = 1'b0;
        if (in_hold) begin
            pads_o.oe[rdpc_pkg::PIN_DBG] = 1'b0;
            pads_o.out[rdpc_pkg::PIN_DBG] = 1'b0;
        end else if (dbg_sel_q) begin
            pads_o.oe[rdpc_pkg::PIN_DBG] = (tx_cnt_q != '0)
                && (tx_cnt_q <= tx_low + rdpc_pkg::SPEEDUP_CYCLES);
            pads_o.out[rdpc_pkg::PIN_DBG] = (tx_cnt_q > tx_low);
        end else if (cmp_sel_q) begin
            pads_o.oe[rdpc_pkg::PIN_DBG] = 1'b1;
            pads_o.out[rdpc_pkg::PIN_DBG] = comparator_output_i;
        end
        base_pu = pull_en_q & ~pads_o.oe;
        pads_o.pu = base_pu;
        pads_o.pd = '0;
        for (int i = 0; i < rdpc_pkg::NUM_KEYS; i++) begin
            if (key_sel_q[i] && key_pol_q[i] && base_pu[i]) begin
                pads_o.pu[i] = 1'b0;
                pads_o.pd[i] = 1'b1;
            end
        end
        if (rst_sel_q) begin
            pads_o.pu[rdpc_pkg::PIN_RST] = 1'b1;
        end else if (irq_sel_q) begin
            pads_o.pu[rdpc_pkg::PIN_RST] = !irq_pdis_q;
        end
        if (dbg_sel_q) begin
            pads_o.pu[rdpc_pkg::PIN_DBG] = 1'b1;
            pads_o.pd[rdpc_pkg::PIN_DBG] = 1'b0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_por_port;
        @(posedge clk_i) $past(rst_i) && !rst_i
        |-> !rst_sel_q && !pads_o.oe[rdpc_pkg::PIN_RST];
    endproperty
    a_por_port: assert property (p_por_port) else $error("shared pin not port after POR");

    property p_rst_sel_set;
        @(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && we_i && ack_q && sel_i[0] && !in_hold
        && adr_i == rdpc_pkg::OFF_SYS_OPT && dat_i[rdpc_pkg::BIT_RST_SEL] |=> rst_sel_q;
    endproperty
    a_rst_sel_set: assert property (p_rst_sel_set) else $error("reset select not set");

    property p_rst_sticky;
        @(posedge clk_i) disable iff (rst_i) rst_sel_q && !rst_i |=> rst_sel_q;
    endproperty
    a_rst_sticky: assert property (p_rst_sticky) else $error("reset select reverted");

    property p_pin_reset;
        @(posedge clk_i) disable iff (rst_i)
        rst_sel_q && !pad_in_i[rdpc_pkg::PIN_RST] |=> chip_reset_o [*2];
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("reset pin ignored");

    property p_rst_pull;
        @(posedge clk_i) disable iff (rst_i) rst_sel_q |-> pads_o.pu[rdpc_pkg::PIN_RST];
    endproperty
    a_rst_pull: assert property (p_rst_pull) else $error("reset pin pullup off");

    property p_irq_pull;
        @(posedge clk_i) disable iff (rst_i)
        irq_sel_q && !rst_sel_q |-> pads_o.pu[rdpc_pkg::PIN_RST] == !irq_pdis_q;
    endproperty
    a_irq_pull: assert property (p_irq_pull) else $error("interrupt pullup wrong");

    property p_out_no_pull;
        @(posedge clk_i) disable iff (rst_i)
        (pads_o.oe[3:0] & (pads_o.pu[3:0] | pads_o.pd[3:0])) == 4'h0
        && !(pads_o.oe[rdpc_pkg::PIN_RST] && pads_o.pu[rdpc_pkg::PIN_RST])
        && !(pads_o.oe[rdpc_pkg::PIN_DBG] && !dbg_sel_q
        && (pads_o.pu[rdpc_pkg::PIN_DBG] || pads_o.pd[rdpc_pkg::PIN_DBG]));
    endproperty
    a_out_no_pull: assert property (p_out_no_pull) else $error("pull on driven pin");

    property p_dbg_after_reset;
        @(posedge clk_i) disable iff (rst_i)
        $fell(chip_reset_o) |-> dbg_sel_q && pads_o.pu[rdpc_pkg::PIN_DBG];
    endproperty
    a_dbg_after_reset: assert property (p_dbg_after_reset) else $error("debug select lost");

    property p_pin_user;
        @(posedge clk_i) disable iff (rst_i)
        $fell(chip_reset_o) && cause_q == rdpc_pkg::CAUSE_PIN |-> !bg_mode_q;
    endproperty
    a_pin_user: assert property (p_pin_user) else $error("pin reset entered background");

    property p_strap;
        @(posedge clk_i) disable iff (rst_i)
        $fell(chip_reset_o) && cause_q != rdpc_pkg::CAUSE_PIN
        |-> bg_mode_q == !$past(pad_in_i[rdpc_pkg::PIN_DBG]);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not latched");

    property p_bit_time;
        @(posedge clk_i) disable iff (rst_i || in_hold)
        tx_go |=> pads_o.oe[rdpc_pkg::PIN_DBG] [*4] ##13 tx_done_q;
    endproperty
    a_bit_time: assert property (p_bit_time) else $error("debug bit time wrong");

endmodule

/* rdpc_host.sv */
module rdpc_host (
    // Clock
    input wire logic clk_i,
    // Device pads
    input rdpc_pkg::rdpc_pads_t pads_i,
    // Bench commands
    input wire logic rst_low_i,
    input wire logic strap_low_i,
    input wire logic [3:0] port_i,
    // Resolved pad levels
    output logic [5:0] pad_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // Wire resolution
    // ************************************************************
    logic flip_q = 1'b0;
    always_ff @(posedge clk_i) begin
        flip_q <= ~flip_q;
    end
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pad_o[i] = pads_i.oe[i] ? pads_i.out[i] : port_i[i];
        end
        // Reset source pulls low, else pullup or floating
        if (rst_low_i) begin
            pad_o[5] = 1'b0;
        end else begin
            pad_o[5] = pads_i.pu[5] ? 1'b1 : flip_q;
        end
        // Debug host strap low wins over the pseudo open drain
        if (strap_low_i || (pads_i.oe[4] && !pads_i.out[4])) begin
            pad_o[4] = 1'b0;
        end else if (pads_i.oe[4]) begin
            pad_o[4] = 1'b1;
        end else begin
            pad_o[4] = pads_i.pu[4] ? 1'b1 : flip_q;
        end
    end
endmodule

/* rdpc_top_bench.sv */
module rdpc_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ************************************************************
    // Wiring
    // ************************************************************
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, cmp_i = 1'b0, tx_start = 1'b0, tx_bit = 1'b0, tx_done, rx, chip_reset, bg;
    logic rst_low = 1'b0, strap_low = 1'b0;
    logic [5:0] pad_in;
    rdpc_pkg::rdpc_pads_t pads;
    int mismatches = 0;
    int compares = 0;
    always #12.5 clk_i = ~clk_i;
    rdpc_top #(.RST_HOLD(8)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .pad_in_i(pad_in), .pads_o(pads), .comparator_output_i(cmp_i),
        .bdc_tx_start_i(tx_start), .bdc_tx_bit_i(tx_bit), .bdc_tx_done_o(tx_done),
        .bdc_rx_o(rx), .chip_reset_o(chip_reset), .background_halt_mode_o(bg));
    rdpc_host host (.clk_i(clk_i), .pads_i(pads), .rst_low_i(rst_low), .strap_low_i(strap_low),
        .port_i(4'h5), .pad_o(pad_in));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) check("ack", 32'h0, 32'h1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask
    task automatic step;
        @(posedge clk_i);
        #1;
    endtask
    task automatic wait_run;
        int n;
        n = 0;
        step;
        while (chip_reset !== 1'b0 && n < 100) begin
            step;
            n++;
        end
        check("boot", 32'(chip_reset), 32'h0);
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_defaults;
        wb(1'b0, rdpc_pkg::OFF_SYS_OPT, 4'hF, 32'h0);
        check("sys_opt", rd, 32'h08);
        check("pu5", 32'(pads.pu[5]), 32'h0);
        check("pu4", 32'(pads.pu[4]), 32'h1);
        check("bg", 32'(bg), 32'h0);
        @(posedge clk_i) rst_low <= 1'b1;
        repeat (3) step;
        check("port_reset", 32'(chip_reset), 32'h0);
        @(posedge clk_i) rst_low <= 1'b0;
        wb(1'b0, rdpc_pkg::OFF_STATUS, 4'hF, 32'h0);
        check("status", rd, 32'h0);
        wb(1'b0, 8'h20, 4'hF, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask
    task automatic t_pulls;
        wb(1'b1, rdpc_pkg::OFF_SYS_OPT, 4'hF, 32'h0A);
        step;
        check("irq_pu", 32'(pads.pu[5]), 32'h1);
        wb(1'b1, rdpc_pkg::OFF_SYS_OPT, 4'hF, 32'h0E);
        step;
        check("irq_pdis", 32'(pads.pu[5]), 32'h0);
        wb(1'b1, rdpc_pkg::OFF_PULL_EN, 4'hE, 32'h3F);
        wb(1'b0, rdpc_pkg::OFF_PULL_EN, 4'hF, 32'h0);
        check("no_sel", rd, 32'h0);
        wb(1'b1, rdpc_pkg::OFF_PULL_EN, 4'hF, 32'h0F);
        wb(1'b1, rdpc_pkg::OFF_PIN_DIR, 4'hF, 32'h01);
        step;
        check("pu_in", 32'(pads.pu[3:0]), 32'h0E);
        wb(1'b1, rdpc_pkg::OFF_KEYPAD, 4'hF, 32'h22);
        step;
        check("kb_pu", 32'(pads.pu[3:0]), 32'h0C);
        check("kb_pd", 32'(pads.pd[3:0]), 32'h02);
        wb(1'b1, rdpc_pkg::OFF_PORT_OUT, 4'hF, 32'h3E);
        wb(1'b0, rdpc_pkg::OFF_PORT_OUT, 4'hF, 32'h0);
        check("port_out_rd", rd, 32'h3E);
        check("port_out", 32'(pads.out[3:0]), 32'hE);
        wb(1'b0, rdpc_pkg::OFF_PIN_IN, 4'hF, 32'h0);
        check("pin_in", rd & 32'h1F, 32'h14);
    endtask
    task automatic send_bit(input logic b, input logic [4:0] low);
        int n, lows, ups;
        @(posedge clk_i);
        tx_start <= 1'b1;
        tx_bit <= b;
        @(posedge clk_i);
        tx_start <= 1'b0;
        n = 0;
        lows = 0;
        ups = 0;
        #1;
        check("rx_low", 32'(rx), 32'h0);
        while (tx_done !== 1'b1 && n < 40) begin
            if (pads.oe[4] === 1'b1 && pads.out[4] === 1'b0) lows++;
            if (pads.oe[4] === 1'b1 && pads.out[4] === 1'b1) ups++;
            step;
            n++;
        end
        check("bit_time", n, 32'(rdpc_pkg::BIT_CYCLES));
        check("low_time", lows, 32'(low));
        check("speedup", ups, 32'(rdpc_pkg::SPEEDUP_CYCLES));
        check("rx_idle", 32'(rx), 32'h1);
    endtask
    task automatic t_debug;
        send_bit(1'b1, rdpc_pkg::LOW_ONE);
        send_bit(1'b0, rdpc_pkg::LOW_ZERO);
        wb(1'b1, rdpc_pkg::OFF_SYS_OPT, 4'hF, 32'h10);
        @(posedge clk_i) cmp_i <= 1'b1;
        step;
        check("cmp_pin", 32'({pads.oe[4], pads.out[4], pads.pu[4]}), 32'h6);
    endtask
    task automatic t_force(input logic lo);
        @(posedge clk_i) strap_low <= lo;
        wb(1'b1, rdpc_pkg::OFF_DBG_FORCE, 4'hF, 32'h1);
        step;
        check("force_rst", 32'(chip_reset), 32'h1);
        check("ms_input", 32'(pads.oe[4]), 32'h0);
        wait_run;
        @(posedge clk_i) strap_low <= 1'b0;
        step;
        check("bg_force", 32'(bg), 32'(lo));
        check("bkgd_pu", 32'(pads.pu[4]), 32'h1);
        wb(1'b0, rdpc_pkg::OFF_STATUS, 4'hF, 32'h0);
        check("status_f", rd, 32'({rdpc_pkg::CAUSE_FORCE, lo}));
        wb(1'b0, rdpc_pkg::OFF_SYS_OPT, 4'hF, 32'h0);
        check("opt_force", rd, 32'h08);
    endtask
    task automatic t_pin;
        wb(1'b1, rdpc_pkg::OFF_SYS_OPT, 4'hF, 32'h01);
        step;
        check("rst_pu", 32'(pads.pu[5]), 32'h1);
        @(posedge clk_i) strap_low <= 1'b1;
        rst_low <= 1'b1;
        repeat (3) step;
        check("pin_rst", 32'(chip_reset), 32'h1);
        @(posedge clk_i) rst_low <= 1'b0;
        wait_run;
        check("bg_pin", 32'(bg), 32'h0);
        @(posedge clk_i) strap_low <= 1'b0;
        wb(1'b1, rdpc_pkg::OFF_SYS_OPT, 4'hF, 32'h0);
        wb(1'b0, rdpc_pkg::OFF_SYS_OPT, 4'hF, 32'h0);
        check("sticky", rd, 32'h01);
        wb(1'b0, rdpc_pkg::OFF_STATUS, 4'hF, 32'h0);
        check("status_p", rd, 32'({rdpc_pkg::CAUSE_PIN, 1'b0}));
        @(posedge clk_i) rst_i <= 1'b1;
        strap_low <= 1'b1;
        @(posedge clk_i) rst_i <= 1'b0;
        wait_run;
        @(posedge clk_i) strap_low <= 1'b0;
        step;
        check("bg_por", 32'(bg), 32'h1);
        wb(1'b0, rdpc_pkg::OFF_STATUS, 4'hF, 32'h0);
        check("status_por", rd, 32'({rdpc_pkg::CAUSE_POR, 1'b1}));
        wb(1'b0, rdpc_pkg::OFF_SYS_OPT, 4'hF, 32'h0);
        check("por_clear", rd, 32'h08);
    endtask
    // ************************************************************
    // Sequence and verdict
    // ************************************************************
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_run;
        t_defaults;
        t_pulls;
        t_debug;
        t_force(1'b1);
        t_force(1'b0);
        t_pin;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        wrap_up;
    end
endmodule
